// [rtl/pcc_top.sv]
// What this block does
// - Accept 8-bit 4:2:2 with external syncs.
// - Accept 8-bit 4:2:2 timed by embedded codes.
// - Accept 1120 at 8/16 bits, single/dual edge.
// - Separate two or four interleaved channels.
// - Capture with pixel clock up to 148.5 MHz; oversampling caps it near half of clk_in.
// - Raw samples sit at the bus top.
// - Wide 1120 default: low byte luma.
// - 1120 timing from embedded codes only.
// - Swap puts luma on the high byte.
// - 8-bit YC modes sample bus bits 15:8.
// - Drive a reference clock to the sensor.
// - Sample data on the received pixel clock.
// - Line sync qualifies pixel capture in the externally synced modes (BT601, raw).
// - Frame sync starts and ends frames in the externally synced modes (BT601, raw).
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module pcc_top (
   // Clock and reset.
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   // Register port.
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [31:0] reg_rdata_out,
   // Camera pins.
   input  wire logic        pixel_clock_in,
   input  wire logic [15:0] par_cam_data,
   input  wire logic        line_valid_in,
   input  wire logic        frame_sync_in,
   output logic             sensor_clock_out,
   // Pixel stream.
   output logic             pix_valid_out,
   output logic      [15:0] pix_data_out,
   output logic      [1:0]  pix_chan_out,
   output logic             pix_frame_start_out
);
   import pcc_pkg::*;

   function automatic logic is_emb(input pcc_mode_t m);
      is_emb = (m == PCC_BT656) || (m == PCC_BT1120) || (m == PCC_MULTI);
   endfunction

   // Registers.
   logic [31:0] ctrl;
   logic [7:0]  clkdiv;
   logic [15:0] frame_count;

   wire       cfg_en    = ctrl[PCC_CTRL_EN];
   wire pcc_mode_t mode = pcc_mode_t'(ctrl[PCC_CTRL_MODE_LO +: 3]);
   wire       cfg_wide  = ctrl[PCC_CTRL_WIDE];
   wire       cfg_dual  = ctrl[PCC_CTRL_DUAL];
   wire       cfg_swap  = ctrl[PCC_CTRL_SWAP];
   wire       cfg_four  = ctrl[PCC_CTRL_FOUR_CH];
   wire [1:0] cfg_raw   = ctrl[PCC_CTRL_RAW_LO +: 2];
   wire       cfg_sclk  = ctrl[PCC_CTRL_SCLK_EN];

   wire sel_ctrl = reg_addr_in == PCC_REG_CTRL;
   wire sel_div  = reg_addr_in == PCC_REG_CLKDIV;
   wire sel_stat = reg_addr_in == PCC_REG_STATUS;

   // Pin synchronisers: every pin passes two flops before use.
   logic [18:0] pin_s1;
   logic [18:0] pin_s2;
   logic        pclk_d;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pin_s1 <= 19'h0_0000;
         pin_s2 <= 19'h0_0000;
         pclk_d <= 1'b0;
      end else begin
         pin_s1 <= {pixel_clock_in, line_valid_in, frame_sync_in,
                    par_cam_data};
         pin_s2 <= pin_s1;
         pclk_d <= pin_s2[18];
      end
   end

   // Oversampling the pixel clock caps it near half of clk_in; faster
   // sensors need a capture clock raised to match.
   wire        pclk_s  = pin_s2[18];
   wire        lv_s    = pin_s2[17];
   wire        fs_s    = pin_s2[16];
   wire [15:0] bus     = pin_s2[15:0];
   wire        p_rise  = pclk_s & ~pclk_d;
   wire        p_fall  = ~pclk_s & pclk_d;
   wire        samp_en = p_rise | (cfg_dual & p_fall);

   wire emb  = is_emb(mode);
   wire wide = (mode == PCC_BT1120) && cfg_wide;
   // Codes ride on the luma lane of a wide bus.
   wire [7:0] key = !wide ? bus[15:8] : (cfg_swap ? bus[15:8] : bus[7:0]);

   logic [15:0] dec_word;
   logic        code_hit;
   logic [7:0]  code_xy;

   pcc_code_det #(.W(16)) u_code (
      .clk_in     (clk_in),
      .rst_b_in   (rst_b_in),
      .samp_en_in (samp_en),
      .word_in    (bus),
      .key_in     (key),
      .word_out   (dec_word),
      .hit_out    (code_hit),
      .xy_out     (code_xy)
   );

   // Frame and line tracking.
   logic       fs_prev;
   logic       lv_prev;
   logic       v_prev;
   logic       in_frame;
   logic       line_act;
   logic [2:0] skip;
   logic       phase;
   logic [7:0] chroma_hold;
   logic [1:0] chan;
   logic       start_pend;

   wire code_v    = code_xy[PCC_XY_V];
   wire sav       = emb && code_hit && !code_xy[PCC_XY_H];
   wire eav       = emb && code_hit && code_xy[PCC_XY_H];
   wire ext_start = samp_en && fs_s && !fs_prev;
   wire ext_end   = samp_en && !fs_s && fs_prev;
   wire emb_start = sav && !code_v && v_prev;
   wire emb_end   = code_hit && code_v && !v_prev;
   wire f_start   = emb ? emb_start : ext_start;
   wire f_end     = emb ? emb_end : ext_end;
   wire line_rise = samp_en && lv_s && !lv_prev;
   wire line_new  = emb ? (sav && !code_v) : line_rise;
   wire line_ok   = emb ? (line_act && skip == 3'h0) : lv_s;
   wire take      = samp_en && in_frame && line_ok;
   wire first_byte = line_new || !phase;
   wire pair_done = (mode == PCC_RAW) || wide || !first_byte;
   wire [1:0] chan_mask = cfg_four ? 2'h3 : 2'h1;

   // 8-bit YC modes take the byte from bus bits 15:8.
   wire [7:0] yc_byte = emb ? dec_word[15:8] : bus[15:8];

   logic [15:0] raw_word;
   always_comb begin
      case (cfg_raw)
         PCC_RAW8:  raw_word = {8'h00, bus[15:8]};
         PCC_RAW10: raw_word = {6'h00, bus[15:6]};
         PCC_RAW12: raw_word = {4'h0, bus[15:4]};
         default:   raw_word = bus;
      endcase
   end

   logic [15:0] next_data;
   always_comb begin
      if (mode == PCC_RAW) begin
         next_data = raw_word;
      end else if (wide) begin
         next_data = cfg_swap ? {dec_word[7:0], dec_word[15:8]}
                              : dec_word;
      end else begin
         next_data = {chroma_hold, yc_byte};
      end
   end

   wire next_valid = take && pair_done;
   wire next_pend  = f_start || (start_pend && !next_valid);

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         fs_prev  <= 1'b0;
         lv_prev  <= 1'b0;
         v_prev   <= 1'b1;
         in_frame <= 1'b0;
         line_act <= 1'b0;
         skip     <= 3'h0;
      end else begin
         if (samp_en) begin
            fs_prev <= fs_s;
            lv_prev <= lv_s;
         end
         if (code_hit) begin
            v_prev <= code_v;
         end
         if (!cfg_en) begin
            in_frame <= 1'b0;
         end else if (f_start) begin
            in_frame <= 1'b1;
         end else if (f_end) begin
            in_frame <= 1'b0;
         end
         if (sav) begin
            line_act <= !code_v;
            skip     <= PCC_HDR_SKIP;
         end else if (eav) begin
            line_act <= 1'b0;
         end else if (samp_en && skip != 3'h0) begin
            skip <= skip - 3'h1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         phase       <= 1'b0;
         chroma_hold <= 8'h00;
         chan        <= 2'h0;
         start_pend  <= 1'b0;
      end else begin
         start_pend <= cfg_en && next_pend;
         if (f_start) begin
            phase <= 1'b0;
         end else if (take) begin
            // The sample that opens a line is often taken at once, and it
            // must still count as chroma or every pair slips by one byte.
            phase <= first_byte;
            if (first_byte) begin
               chroma_hold <= yc_byte;
            end
         end else if (line_new) begin
            phase <= 1'b0;
         end
         if (mode != PCC_MULTI) begin
            chan <= 2'h0;
         end else if (sav) begin
            chan <= code_xy[1:0] & chan_mask;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pix_valid_out       <= 1'b0;
         pix_data_out        <= 16'h0000;
         pix_chan_out        <= 2'h0;
         pix_frame_start_out <= 1'b0;
      end else begin
         pix_valid_out       <= next_valid;
         pix_frame_start_out <= next_valid && start_pend;
         if (next_valid) begin
            pix_data_out <= next_data;
            pix_chan_out <= chan;
         end
      end
   end

   // Sensor reference clock: a divider toggles it every clkdiv+1 cycles.
   logic [7:0] sclk_cnt;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sclk_cnt         <= 8'h00;
         sensor_clock_out <= 1'b0;
      end else if (!cfg_sclk) begin
         sclk_cnt         <= 8'h00;
         sensor_clock_out <= 1'b0;
      end else if (sclk_cnt >= clkdiv) begin
         sclk_cnt         <= 8'h00;
         sensor_clock_out <= !sensor_clock_out;
      end else begin
         sclk_cnt <= sclk_cnt + 8'h01;
      end
   end

   // Register port and frame counter.
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl          <= PCC_CTRL_RST;
         clkdiv        <= PCC_CLKDIV_RST;
         frame_count   <= 16'h0000;
         reg_rdata_out <= 32'h0000_0000;
      end else begin
         if (reg_wr_in && sel_ctrl) begin
            ctrl <= reg_wdata_in;
         end
         if (reg_wr_in && sel_div) begin
            clkdiv <= reg_wdata_in[7:0];
         end
         if (in_frame && f_end) begin
            frame_count <= frame_count + 16'h0001;
         end
         reg_rdata_out <= 32'h0000_0000;
         if (reg_rd_in && sel_ctrl) begin
            reg_rdata_out <= ctrl;
         end else if (reg_rd_in && sel_div) begin
            reg_rdata_out <= {24'h00_0000, clkdiv};
         end else if (reg_rd_in && sel_stat) begin
            reg_rdata_out <= {12'h000, chan, line_ok, in_frame,
                              frame_count};
         end
      end
   end

   // Checks.
   logic [8:0] sclk_hold;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sclk_hold <= 9'h000;
      end else if (!cfg_sclk ||
                   sensor_clock_out != $past(sensor_clock_out)) begin
         sclk_hold <= 9'h000;
      end else begin
         sclk_hold <= sclk_hold + 9'h001;
      end
   end

   property p_sclk_rate;
      @(posedge clk_in) disable iff (!rst_b_in)
      cfg_sclk && $stable(clkdiv) |-> sclk_hold <= {1'b0, clkdiv} + 9'h002;
   endproperty
   a_sclk_rate: assert property (p_sclk_rate)
      else $error("sensor clock stalled");

   property p_sampled;
      @(posedge clk_in) disable iff (!rst_b_in)
      pix_valid_out |-> $past(samp_en) && $past(in_frame);
   endproperty
   a_sampled: assert property (p_sampled)
      else $error("pixel without pixel clock edge");

   property p_whole_frame;
      @(posedge clk_in) disable iff (!rst_b_in)
      $rose(in_frame) |-> $past(f_start) && $past(cfg_en);
   endproperty
   a_whole_frame: assert property (p_whole_frame)
      else $error("frame opened without a start");

   property p_line_qual;
      @(posedge clk_in) disable iff (!rst_b_in)
      pix_valid_out && $past(mode) == PCC_BT601 |-> $past(lv_s);
   endproperty
   a_line_qual: assert property (p_line_qual)
      else $error("pixel outside line sync");

   property p_ext_start;
      @(posedge clk_in) disable iff (!rst_b_in)
      $rose(in_frame) && !$past(emb) |-> $past(fs_s) && !$past(fs_prev);
   endproperty
   a_ext_start: assert property (p_ext_start)
      else $error("frame start without frame sync edge");

   property p_emb_only;
      @(posedge clk_in) disable iff (!rst_b_in)
      $rose(in_frame) && $past(emb) |-> $past(code_hit);
   endproperty
   a_emb_only: assert property (p_emb_only)
      else $error("embedded mode used external sync");

   property p_raw12;
      @(posedge clk_in) disable iff (!rst_b_in)
      pix_valid_out && $past(mode) == PCC_RAW && $past(cfg_raw) == PCC_RAW12
      |-> pix_data_out == {4'h0, $past(bus[15:4])};
   endproperty
   a_raw12: assert property (p_raw12)
      else $error("raw sample misaligned");

   property p_swap;
      @(posedge clk_in) disable iff (!rst_b_in)
      pix_valid_out && $past(wide) && $past(cfg_swap)
      |-> pix_data_out == {$past(dec_word[7:0]), $past(dec_word[15:8])};
   endproperty
   a_swap: assert property (p_swap)
      else $error("swapped lanes wrong");

   property p_yc8;
      @(posedge clk_in) disable iff (!rst_b_in)
      pix_valid_out && $past(mode) == PCC_BT601
      |-> pix_data_out[7:0] == $past(bus[15:8]);
   endproperty
   a_yc8: assert property (p_yc8)
      else $error("8-bit luma not from high byte");

   property p_chan;
      @(posedge clk_in) disable iff (!rst_b_in)
      pix_valid_out && !$past(cfg_four) |-> !pix_chan_out[1];
   endproperty
   a_chan: assert property (p_chan)
      else $error("channel beyond configured count");

   c_frame: cover property (@(posedge clk_in) disable iff (!rst_b_in)
      pix_frame_start_out);
   c_emb: cover property (@(posedge clk_in) disable iff (!rst_b_in)
      pix_valid_out && $past(emb));
   c_raw: cover property (@(posedge clk_in) disable iff (!rst_b_in)
      pix_valid_out && $past(mode) == PCC_RAW);

endmodule // pcc_top

// [rtl/pcc_pkg.sv]
package pcc_pkg;

   // Register offsets, byte addresses on the plain register port.
   localparam logic [7:0] PCC_REG_CTRL   = 8'h00;
   localparam logic [7:0] PCC_REG_CLKDIV = 8'h04;
   localparam logic [7:0] PCC_REG_STATUS = 8'h08;

   // Control register field positions.
   localparam int PCC_CTRL_EN       = 0;
   localparam int PCC_CTRL_MODE_LO  = 1;
   localparam int PCC_CTRL_WIDE     = 4;
   localparam int PCC_CTRL_DUAL     = 5;
   localparam int PCC_CTRL_SWAP     = 6;
   localparam int PCC_CTRL_FOUR_CH  = 7;
   localparam int PCC_CTRL_RAW_LO   = 8;
   localparam int PCC_CTRL_SCLK_EN  = 16;

   // Status register field positions.
   localparam int PCC_STAT_COUNT_LO = 0;
   localparam int PCC_STAT_IN_FRAME = 16;
   localparam int PCC_STAT_LINE     = 17;
   localparam int PCC_STAT_CHAN_LO  = 18;

   // Reset values.
   localparam logic [31:0] PCC_CTRL_RST   = 32'h0000_0000;
   localparam logic [7:0]  PCC_CLKDIV_RST = 8'h03;

   // Embedded timing reference code preamble and its flag bits.
   localparam logic [7:0] PCC_CODE_FF = 8'hFF;
   localparam logic [7:0] PCC_CODE_00 = 8'h00;
   localparam int PCC_XY_V = 5;
   localparam int PCC_XY_H = 4;

   // Samples that the code preamble and code word occupy in the pipeline.
   localparam logic [2:0] PCC_HDR_SKIP = 3'h4;

   // Raw sample widths.
   localparam logic [1:0] PCC_RAW8  = 2'h0;
   localparam logic [1:0] PCC_RAW10 = 2'h1;
   localparam logic [1:0] PCC_RAW12 = 2'h2;

   typedef enum logic [2:0] {
      PCC_BT601  = 3'b000,
      PCC_BT656  = 3'b001,
      PCC_BT1120 = 3'b010,
      PCC_MULTI  = 3'b011,
      PCC_RAW    = 3'b100
   } pcc_mode_t;

endpackage

// [rtl/pcc_code_det.sv]
`timescale 1ns/1ps
module pcc_code_det #(
   parameter int W = 16
) (
   // Clock and reset.
   input  wire logic         clk_in,
   input  wire logic         rst_b_in,
   // Sample stream.
   input  wire logic         samp_en_in,
   input  wire logic [W-1:0] word_in,
   input  wire logic [7:0]   key_in,
   // Delayed stream and code detection.
   output logic      [W-1:0] word_out,
   output logic              hit_out,
   output logic      [7:0]   xy_out
);
   import pcc_pkg::*;

   // The word leaves four samples late, so a code found now still lets
   // the caller blank its preamble before it reaches the output.
   logic [W-1:0] word_q [0:3];
   logic [7:0]   key_q  [0:2];

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < 4; i++) begin
            word_q[i] <= '0;
         end
         for (int i = 0; i < 3; i++) begin
            key_q[i] <= 8'h00;
         end
      end else if (samp_en_in) begin
         word_q[0] <= word_in;
         key_q[0]  <= key_in;
         for (int i = 1; i < 4; i++) begin
            word_q[i] <= word_q[i-1];
         end
         for (int i = 1; i < 3; i++) begin
            key_q[i] <= key_q[i-1];
         end
      end
   end

   assign word_out = word_q[3];
   assign xy_out   = key_in;
   assign hit_out  = samp_en_in && key_q[2] == PCC_CODE_FF &&
                     key_q[1] == PCC_CODE_00 && key_q[0] == PCC_CODE_00;

endmodule // pcc_code_det

// [tb/pcc_cam_model.sv]
`timescale 1ns/1ps
module pcc_cam_model (
   // Pacing clock.
   input  wire logic        clk_in,
   // Camera pins.
   output logic             pixel_clock_out,
   output logic      [15:0] cam_data_out,
   output logic             line_valid_out,
   output logic             frame_sync_out
);
   // The pins carry pull-downs, so a stopped link sits at 0.
   initial begin
      pixel_clock_out = 1'b0;
      cam_data_out    = 16'h0000;
      line_valid_out  = 1'b0;
      frame_sync_out  = 1'b0;
   end

   // One pixel period of ten capture clocks; lines change in the low phase
   // so they are steady long before and after the rising edge.
   task automatic word(input logic [15:0] d, input logic lv, input logic fs);
      @(posedge clk_in);
      pixel_clock_out <= 1'b0;
      cam_data_out    <= d;
      line_valid_out  <= lv;
      frame_sync_out  <= fs;
      repeat (5) @(posedge clk_in);
      pixel_clock_out <= 1'b1;
      repeat (4) @(posedge clk_in);
   endtask

   task automatic idle();
      @(posedge clk_in);
      pixel_clock_out <= 1'b0;
      cam_data_out    <= 16'h0000;
      line_valid_out  <= 1'b0;
      frame_sync_out  <= 1'b0;
   endtask
endmodule // pcc_cam_model

// [tb/parallel_camera_capture_tb.sv]
`timescale 1ns/1ps
module parallel_camera_capture_tb;
   import pcc_pkg::*;
   logic        clk_in, rst_b_in, reg_wr_in, reg_rd_in;
   logic [7:0]  reg_addr_in;
   logic [31:0] reg_wdata_in, reg_rdata_out, rd, st0;
   logic        pclk, lv, fs, sclk, pv, pfs;
   logic [15:0] bus, pdata;
   logic [1:0]  pchan;
   int          err_total, comparisons, starts, gap;
   logic [17:0] got[$], exp[$];
   logic [6:0]  emb[6];

   pcc_top DUT (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .pixel_clock_in(pclk),
      .par_cam_data(bus), .line_valid_in(lv), .frame_sync_in(fs),
      .sensor_clock_out(sclk), .pix_valid_out(pv), .pix_data_out(pdata),
      .pix_chan_out(pchan), .pix_frame_start_out(pfs));

   pcc_cam_model cam (.clk_in(clk_in), .pixel_clock_out(pclk),
      .cam_data_out(bus), .line_valid_out(lv), .frame_sync_out(fs));

   task automatic check(string what, logic [31:0] seen, logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, want, seen);
      end
   endtask

   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic reg_write(logic [7:0] a, logic [31:0] d);
      @(posedge clk_in);
      reg_wr_in    <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge clk_in);
      reg_wr_in    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic reg_read(logic [7:0] a, output logic [31:0] d);
      @(posedge clk_in);
      reg_rd_in   <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_in);
      reg_rd_in   <= 1'b0;
      #1 d = reg_rdata_out;
   endtask

   function automatic logic [31:0] ctrl(logic [2:0] m, logic [3:0] f,
                                        logic [1:0] rw);
      return 32'h1 | 32'(m) << PCC_CTRL_MODE_LO | 32'(f) << PCC_CTRL_WIDE
             | 32'(rw) << PCC_CTRL_RAW_LO;
   endfunction

   always @(posedge clk_in) begin
      if (pv === 1'b1)
         got.push_back({pchan, pdata});
      if (pfs === 1'b1)
         starts++;
   end

   task automatic cmp_frame(int n);
      repeat (30) @(posedge clk_in);
      check("pixel count", got.size(), exp.size());
      foreach (exp[i])
         if (i < got.size())
            check("pixel", got[i], exp[i]);
      check("frame starts", starts, n);
      got.delete();
      exp.delete();
      starts = 0;
   endtask

   task automatic frame_end();
      cam.word(16'h0000, 1'b0, 1'b1);
      cam.word(16'h0000, 1'b0, 1'b0);
      cam.idle();
   endtask

   task automatic raw_frame(logic [1:0] rw, logic dual, int n);
      logic [15:0] w;
      cam.word(16'h0000, 1'b0, 1'b1);
      cam.word(16'hFFFF, 1'b0, 1'b1);
      reg_read(PCC_REG_STATUS, rd);
      check("in frame", rd[16], 1'b1);
      for (int i = 0; i < n; i++) begin
         w = 16'($urandom);
         cam.word(w, 1'b1, 1'b1);
         // Dual-edge capture sees each word on both pixel clock edges.
         repeat (dual ? 2 : 1)
            exp.push_back({2'b00, 16'(w >> (rw == 2'h3 ? 0 : 8 - 2 * rw))});
      end
      frame_end();
   endtask

   task automatic yc601_frame(int n);
      logic [7:0] c, l;
      cam.word(16'h0000, 1'b0, 1'b1);
      for (int i = 0; i < n; i++) begin
         c = 8'($urandom);
         l = 8'($urandom);
         cam.word({c, 8'($urandom)}, 1'b1, 1'b1);
         cam.word({l, 8'($urandom)}, 1'b1, 1'b1);
         exp.push_back({2'b00, c, l});
      end
      // A lone chroma byte has no partner and must not come out.
      cam.word(16'hA500, 1'b1, 1'b1);
      frame_end();
   endtask

   task automatic code(logic wide, logic [7:0] xy);
      cam.word(wide ? 16'hFFFF : 16'hFF00, 1'b0, 1'b0);
      cam.word(16'h0000, 1'b0, 1'b0);
      cam.word(16'h0000, 1'b0, 1'b0);
      cam.word(wide ? {xy, xy} : {xy, 8'h00}, 1'b0, 1'b0);
   endtask

   // Frame sync is toggled and line valid held low during data to show they are ignored here.
   task automatic emb_frame(logic [3:0] f, logic multi, int n);
      logic [15:0] w;
      logic [1:0]  ch;
      code(f[0], 8'hB0);
      for (int ln = 2; ln < 4; ln++) begin
         code(f[0], 8'h80 | 8'(ln));
         ch = multi ? (f[3] ? 2'(ln) : 2'(ln) & 2'h1) : 2'h0;
         for (int i = 0; i < n; i++) begin
            w = {8'(1 + $urandom % 254), 8'(1 + $urandom % 254)};
            if (f[0]) begin
               cam.word(w, 1'b0, 1'b1);
               exp.push_back({ch, f[2] ? {w[7:0], w[15:8]} : w});
            end else begin
               cam.word({w[15:8], 8'($urandom)}, 1'b0, 1'b1);
               cam.word({w[7:0], 8'($urandom)}, 1'b0, 1'b0);
               exp.push_back({ch, w});
            end
         end
         code(f[0], 8'h90 | 8'(ln));
      end
      code(f[0], 8'hB0);
      cam.idle();
   endtask

   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   initial begin
      #400000;
      err_total++;
      print_verdict();
   end

   initial begin
      emb = '{{PCC_BT656, 4'h0}, {PCC_BT1120, 4'h0}, {PCC_BT1120, 4'h1},
              {PCC_BT1120, 4'h5}, {PCC_MULTI, 4'h0}, {PCC_MULTI, 4'h8}};
      rst_b_in     = 1'b0;
      reg_wr_in    = 1'b0;
      reg_rd_in    = 1'b0;
      reg_addr_in  = 8'h00;
      reg_wdata_in = 32'h0000_0000;
      void'($urandom(32'h9238));
      repeat (6) @(posedge clk_in);
      rst_b_in <= 1'b1;
      reg_read(PCC_REG_CTRL, rd);
      check("ctrl reset", rd, PCC_CTRL_RST);
      @(posedge clk_in);
      #1 check("read data after slot", reg_rdata_out, 32'h0);
      reg_read(PCC_REG_CLKDIV, rd);
      check("clkdiv reset", rd, {24'h0, PCC_CLKDIV_RST});
      reg_write(8'h0C, 32'hFFFF_FFFF);
      reg_read(8'h0C, rd);
      check("unmapped read", rd, 32'h0);
      reg_write(PCC_REG_STATUS, 32'hFFFF_FFFF);
      reg_read(PCC_REG_STATUS, rd);
      check("status read only", rd, 32'h0);
      // Enabling in mid-frame must wait for a fresh frame start.
      reg_write(PCC_REG_CTRL, ctrl(PCC_RAW, 4'h0, PCC_RAW12) & ~32'h1);
      cam.word(16'h0000, 1'b0, 1'b1);
      cam.word(16'h1230, 1'b1, 1'b1);
      reg_write(PCC_REG_CTRL, ctrl(PCC_RAW, 4'h0, PCC_RAW12));
      cam.word(16'h4560, 1'b1, 1'b1);
      frame_end();
      cmp_frame(0);
      for (int rw = 0; rw < 4; rw++) begin
         reg_write(PCC_REG_CTRL, ctrl(PCC_RAW, 4'h0, 2'(rw)));
         reg_read(PCC_REG_STATUS, st0);
         raw_frame(2'(rw), 1'b0, 5);
         cmp_frame(1);
         reg_read(PCC_REG_STATUS, rd);
         check("frame count", rd[15:0], st0[15:0] + 16'h1);
         check("status flags", rd[19:16], 4'h0);
      end
      reg_write(PCC_REG_CTRL, ctrl(PCC_RAW, 4'h2, 2'h3));
      raw_frame(2'h3, 1'b1, 3);
      cmp_frame(1);
      reg_write(PCC_REG_CTRL, ctrl(PCC_BT601, 4'h0, 2'h0));
      yc601_frame(4);
      cmp_frame(1);
      for (int i = 0; i < 6; i++) begin
         reg_write(PCC_REG_CTRL, ctrl(emb[i][6:4], emb[i][3:0], 2'h0));
         emb_frame(emb[i][3:0], emb[i][6:4] == PCC_MULTI, 3);
         cmp_frame(1);
      end
      reg_write(PCC_REG_CLKDIV, 32'h2);
      reg_write(PCC_REG_CTRL, 32'h1 << PCC_CTRL_SCLK_EN);
      for (int k = 0; k < 2; k++) begin
         gap = 0;
         rd[0] = sclk;
         do begin
            @(posedge clk_in);
            #1 gap++;
         end while (sclk === rd[0] && gap < 50);
      end
      check("sensor clock half period", gap, 3);
      reg_write(PCC_REG_CTRL, 32'h0);
      repeat (8) @(posedge clk_in);
      check("sensor clock idle", sclk, 1'b0);
      print_verdict();
   end
endmodule // parallel_camera_capture_tb
